// ### rtl/frx_map.svh
/*
  Constants of the receive framing block: bit patterns, symbol codes and
  hold-off counts. Assumes inclusion by the framing module and the testbench.
*/
`ifndef FRX_MAP_SVH
`define FRX_MAP_SVH
`define FRX_MODE_BYPASS_BIT 7
`define FRX_SYM_LAST        3'h4
`define FRX_PAT_JK          10'h311
`define FRX_PAT_HH          10'h084
`define FRX_PAT_HQ          10'h080
`define FRX_CODE_IDLE       5'h1F
`define FRX_CODE_HALT       5'h04
`define FRX_CODE_J          5'h18
`define FRX_CODE_K          5'h11
`define FRX_CODE_T          5'h0D
`define FRX_CODE_R          5'h07
`define FRX_CODE_S          5'h19
`define FRX_CODE_QUIET      5'h00
`define FRX_BITS_PER_BYTE   10
`define FRX_JK_HOLD_TENTHS  15
`define FRX_JK_HOLD_BITS    ((`FRX_JK_HOLD_TENTHS * `FRX_BITS_PER_BYTE + 9) / 10)
`define FRX_RECTR_TENTHS    28
`define FRX_RECTR_BITS      ((`FRX_RECTR_TENTHS * `FRX_BITS_PER_BYTE) / 10)
`define FRX_IDLE_PAIRS      2
`define FRX_IDLE_SYMS       (`FRX_IDLE_PAIRS * 2)
`endif

// ### rtl/frx_pkg.sv
/*
  Types of the receive framing block.
  Assumes frx_map.svh is compiled alongside.
*/
package frx_pkg;
  typedef enum logic [1:0] {
    FRX_LC_UNKNOWN = 2'h0,
    FRX_LC_IDLE    = 2'h1,
    FRX_LC_ACTIVE  = 2'h3
  } frx_line_type;

  typedef enum logic [3:0] {
    FRX_SC_DATA, FRX_SC_IDLE, FRX_SC_HALT, FRX_SC_QUIET, FRX_SC_J,
    FRX_SC_K, FRX_SC_T, FRX_SC_R, FRX_SC_S, FRX_SC_VIOL
  } frx_class_type;

  typedef struct packed {
    frx_class_type cls;
    logic          ctl;
    logic          viol;
    logic [3:0]    sym;
  } frx_sym_type;

  typedef struct packed {
    logic [1:0]   pinBit;
    logic [2:0]   pinTgl;
    logic [1:0]   sdSync;
    logic         lineLast;
    logic [9:0]   shiftWin;
    logic [2:0]   phase;
    logic         pairTgl;
    logic [4:0]   code;
    logic         codeVld;
    logic         codePairEnd;
    logic [3:0]   hiSym;
    logic         hiCtl;
    logic         hiViol;
    logic         prevJ;
    frx_line_type lineCond;
    logic [2:0]   idleCnt;
    logic         jkLock;
    logic         haltLock;
    logic [4:0]   sinceJk;
    logic [4:0]   sinceHalt;
    logic [3:0]   condA;
    logic [2:0]   condB;
  } frx_state_type;

  typedef struct packed {
    logic [1:0][9:0] mem;
    logic            wrPtr;
    logic            rdPtr;
    logic [1:0]      count;
  } frx_buf_type;
endpackage : frx_pkg

// ### rtl/frx_byte_if.sv
/*
  Byte hand-off between the decoder and the two-entry buffer.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface frx_byte_if;
  logic [9:0] data;
  logic       valid;
  logic       ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : frx_byte_if

// ### rtl/frx_pair_buffer.sv
/*
  Two-entry buffer on the decoded byte path.
  Assumes a synchronously released active-low reset.
*/
`timescale 1ns/1ps
module frx_pair_buffer (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rstSyncN,
  // fill side
  frx_byte_if.snk    inPort,
  // drain side
  output logic [9:0] outData,
  output logic       outValid,
  input  wire logic  outReady
);
  frx_pkg::frx_buf_type s_r;
  frx_pkg::frx_buf_type s_nxt;
  logic                 doPush;
  logic                 doPop;

  assign inPort.ready = s_r.count != 2'h2;
  assign outValid     = s_r.count != 2'h0;
  assign outData      = s_r.mem[s_r.rdPtr];

  always_comb
  begin
    s_nxt  = s_r;
    doPush = inPort.valid && inPort.ready;
    doPop  = outValid && outReady;
    if (doPush)
    begin
      s_nxt.mem[s_r.wrPtr] = inPort.data;
      s_nxt.wrPtr          = ~s_r.wrPtr;
    end
    if (doPop)
    begin
      s_nxt.rdPtr = ~s_r.rdPtr;
    end
    s_nxt.count = s_r.count + {1'b0, doPush} - {1'b0, doPop};
  end

  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSyncN);

  buf_no_over_a : assert property (s_r.count <= 2'h2)
    else $error("buffer count above depth");
  buf_fill_a : assert property (doPush && !doPop |=> s_r.count == $past(s_r.count) + 2'h1)
    else $error("push did not grow buffer");
endmodule : frx_pair_buffer

// ### rtl/frx_symbol_framing.sv
/*
  Receive front end: NRZI decode, symbol shifter, framing, 5B/4B and pair
  decode, line condition tracking. Assumes the pin bit arrives with a
  toggle strobe per bit, and loopback bits arrive as same-clock pulses.
*/
`timescale 1ns/1ps
`include "frx_map.svh"
module frx_symbol_framing (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // bit stream from clock recovery (pins)
  input  wire logic rxBitPin,
  input  wire logic rxTogglePin,
  input  wire logic sigDetectPin,
  // bit stream from local transmitter
  input  wire logic loopBit,
  input  wire logic loopBitValid,
  // mode controls
  input  wire logic runEnable,
  input  wire logic shortInternalLoopback,
  input  wire logic rxLineDecodeBypass,
  input  wire logic framingHold,
  input  wire logic condClearA,
  input  wire logic condClearB,
  // decoded bytes
  output logic [9:0] rxByte,
  output logic       rxByteValid,
  input  wire logic  rxByteReady,
  // line condition status
  output logic [1:0] currentReceiveState,
  output logic [3:0] receiveConditionA,
  output logic [2:0] receiveConditionB
);
  logic [1:0]              rstSync_r;
  logic                    rstSyncN;
  frx_pkg::frx_state_type  s_r;
  frx_pkg::frx_state_type  s_nxt;
  frx_pkg::frx_state_type  clr;
  frx_pkg::frx_sym_type    dec;
  frx_byte_if              bytePath ();
  logic                    bitEvt;
  logic                    rawBit;
  logic                    nrzBit;
  logic [9:0]              win;
  logic                    onBnd;
  logic                    isJk;
  logic                    isHalt;
  logic                    active;
  logic                    jkOk;
  logic                    haltOk;
  logic                    realign;
  logic                    symEnd;
  logic                    noSignal;
  logic [3:0]              setA;
  logic [2:0]              setB;

  function automatic frx_pkg::frx_sym_type decode5b(input logic [4:0] c);
    frx_pkg::frx_sym_type r;
    r = '{frx_pkg::FRX_SC_DATA, 1'b0, 1'b0, 4'h0};
    case (c)
      5'h1E: r.sym = 4'h0;
      5'h09: r.sym = 4'h1;
      5'h14: r.sym = 4'h2;
      5'h15: r.sym = 4'h3;
      5'h0A: r.sym = 4'h4;
      5'h0B: r.sym = 4'h5;
      5'h0E: r.sym = 4'h6;
      5'h0F: r.sym = 4'h7;
      5'h12: r.sym = 4'h8;
      5'h13: r.sym = 4'h9;
      5'h16: r.sym = 4'hA;
      5'h17: r.sym = 4'hB;
      5'h1A: r.sym = 4'hC;
      5'h1B: r.sym = 4'hD;
      5'h1C: r.sym = 4'hE;
      5'h1D: r.sym = 4'hF;
      `FRX_CODE_IDLE:  r = '{frx_pkg::FRX_SC_IDLE, 1'b1, 1'b0, 4'hA};
      `FRX_CODE_HALT:  r = '{frx_pkg::FRX_SC_HALT, 1'b1, 1'b0, 4'h1};
      `FRX_CODE_J:     r = '{frx_pkg::FRX_SC_J, 1'b1, 1'b0, 4'hD};
      `FRX_CODE_K:     r = '{frx_pkg::FRX_SC_K, 1'b1, 1'b0, 4'hD};
      `FRX_CODE_T:     r = '{frx_pkg::FRX_SC_T, 1'b1, 1'b0, 4'h5};
      `FRX_CODE_R:     r = '{frx_pkg::FRX_SC_R, 1'b1, 1'b0, 4'h6};
      `FRX_CODE_S:     r = '{frx_pkg::FRX_SC_S, 1'b1, 1'b0, 4'h7};
      `FRX_CODE_QUIET: r = '{frx_pkg::FRX_SC_QUIET, 1'b1, 1'b0, 4'h2};
      default:         r = '{frx_pkg::FRX_SC_VIOL, 1'b1, 1'b1, 4'h2};
    endcase
    return r;
  endfunction : decode5b

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstSync_r <= 2'h0;
    end
    else
    begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstSyncN = rstSync_r[1];

  always_comb
  begin
    s_nxt  = s_r;
    clr    = '0;
    setA   = 4'h0;
    setB   = 3'h0;
    s_nxt.pinBit = {s_r.pinBit[0], rxBitPin};
    s_nxt.pinTgl = {s_r.pinTgl[1:0], rxTogglePin};
    s_nxt.sdSync = {s_r.sdSync[0], sigDetectPin};
    // source select and line decode
    bitEvt = shortInternalLoopback ? loopBitValid : (s_r.pinTgl[2] ^ s_r.pinTgl[1]);
    rawBit = shortInternalLoopback ? loopBit : s_r.pinBit[1];
    nrzBit = rxLineDecodeBypass ? rawBit : (rawBit ^ s_r.lineLast);
    win    = {s_r.shiftWin[8:0], nrzBit};
    onBnd  = s_r.phase == `FRX_SYM_LAST;
    isJk   = win == `FRX_PAT_JK;
    isHalt = (win == `FRX_PAT_HH) || (win == `FRX_PAT_HQ);
    active = s_r.lineCond == frx_pkg::FRX_LC_ACTIVE;
    // JK acceptance: blocked by framingHold; otherwise any in non-active, gated by hold-off and lock in active
    jkOk   = bitEvt && isJk && !framingHold &&
             (!active ||
              ((s_r.sinceJk >= 5'(`FRX_JK_HOLD_BITS)) && (onBnd || !s_r.jkLock)));
    haltOk = bitEvt && isHalt && !onBnd && !framingHold && !s_r.haltLock &&
             !(active && s_r.jkLock);
    realign = jkOk || haltOk;
    symEnd  = bitEvt && (onBnd || realign);
    if (bitEvt)
    begin
      s_nxt.lineLast = rawBit;
      s_nxt.shiftWin = win;
      s_nxt.phase    = symEnd ? 3'h0 : s_r.phase + 3'h1;
      if (s_r.sinceJk != 5'h1F)
      begin
        s_nxt.sinceJk = s_r.sinceJk + 5'h1;
      end
      if (s_r.sinceHalt != 5'h1F)
      begin
        s_nxt.sinceHalt = s_r.sinceHalt + 5'h1;
      end
      if (s_r.haltLock && !active && s_r.sinceHalt >= 5'(`FRX_RECTR_BITS))
      begin
        s_nxt.haltLock = 1'b0;
      end
      if (isHalt && !onBnd && active && s_r.jkLock)
      begin
        setB[1] = 1'b1;
      end
    end
    if (jkOk)
    begin
      s_nxt.jkLock  = 1'b1;
      s_nxt.sinceJk = 5'h0;
    end
    if (haltOk)
    begin
      s_nxt.haltLock  = 1'b1;
      s_nxt.sinceHalt = 5'h0;
    end
    // first decode stage: register each code
    s_nxt.codeVld = symEnd;
    if (symEnd)
    begin
      s_nxt.code        = win[4:0];
      s_nxt.codePairEnd = realign || s_r.pairTgl;
      s_nxt.pairTgl     = realign ? 1'b0 : ~s_r.pairTgl;
    end
    dec = decode5b(s_r.code);
    // second stage: pair plus line condition into byte code
    bytePath.valid = s_r.codeVld && s_r.codePairEnd;
    bytePath.data  = {s_r.hiCtl | dec.ctl,
                      s_r.hiViol | dec.viol | (s_r.lineCond == frx_pkg::FRX_LC_UNKNOWN),
                      s_r.hiSym, dec.sym};
    if (bytePath.valid && !bytePath.ready)
    begin
      setB[2] = 1'b1;
    end
    noSignal = !s_r.sdSync[1] || !runEnable;
    if (s_r.codeVld)
    begin
      if (!s_r.codePairEnd)
      begin
        s_nxt.hiSym  = dec.sym;
        s_nxt.hiCtl  = dec.ctl;
        s_nxt.hiViol = dec.viol;
      end
      if (dec.viol)
      begin
        setB[0] = 1'b1;
      end
      s_nxt.prevJ   = dec.cls == frx_pkg::FRX_SC_J;
      s_nxt.idleCnt = 3'h0;
      case (dec.cls)
        frx_pkg::FRX_SC_K:
        begin
          if (s_r.prevJ)
          begin
            s_nxt.lineCond = frx_pkg::FRX_LC_ACTIVE;
            setA[0]        = !active;
          end
          else
          begin
            s_nxt.lineCond = frx_pkg::FRX_LC_UNKNOWN;
          end
        end
        frx_pkg::FRX_SC_IDLE:
        begin
          s_nxt.jkLock = 1'b0;
          if (s_r.idleCnt != 3'h7)
          begin
            s_nxt.idleCnt = s_r.idleCnt + 3'h1;
          end
          if (s_nxt.idleCnt >= 3'(`FRX_IDLE_SYMS))
          begin
            s_nxt.lineCond = frx_pkg::FRX_LC_IDLE;
            setA[1]        = s_r.lineCond != frx_pkg::FRX_LC_IDLE;
          end
        end
        frx_pkg::FRX_SC_J:
        begin
          s_nxt.lineCond = s_r.lineCond;
        end
        frx_pkg::FRX_SC_DATA, frx_pkg::FRX_SC_T, frx_pkg::FRX_SC_R, frx_pkg::FRX_SC_S:
        begin
          if (dec.cls == frx_pkg::FRX_SC_T)
          begin
            s_nxt.jkLock = 1'b0;
          end
          if (!active)
          begin
            s_nxt.lineCond = frx_pkg::FRX_LC_UNKNOWN;
          end
        end
        default:
        begin
          s_nxt.lineCond = frx_pkg::FRX_LC_UNKNOWN;
        end
      endcase
      if (s_nxt.lineCond == frx_pkg::FRX_LC_UNKNOWN && s_r.lineCond != frx_pkg::FRX_LC_UNKNOWN)
      begin
        setA[2] = 1'b1;
      end
    end
    if (jkOk)
    begin
      s_nxt.prevJ = 1'b1;
    end
    if (noSignal)
    begin
      s_nxt.lineCond = frx_pkg::FRX_LC_UNKNOWN;
      s_nxt.idleCnt  = 3'h0;
      s_nxt.prevJ    = 1'b0;
      setA[3]        = 1'b1;
    end
    // sticky conditions: a set in the clear cycle wins
    s_nxt.condA = (s_r.condA & ~{4{condClearA}}) | setA;
    s_nxt.condB = (s_r.condB & ~{3{condClearB}}) | setB;
    if (!runEnable)
    begin
      clr.pinBit   = s_nxt.pinBit;
      clr.pinTgl   = s_nxt.pinTgl;
      clr.sdSync   = s_nxt.sdSync;
      clr.condA    = s_nxt.condA;
      clr.condB    = s_nxt.condB;
      s_nxt        = clr;
    end
  end

  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  frx_pair_buffer u_buf (
    .clk      (clk),
    .rstSyncN (rstSyncN),
    .inPort   (bytePath),
    .outData  (rxByte),
    .outValid (rxByteValid),
    .outReady (rxByteReady)
  );

  assign currentReceiveState = s_r.lineCond;
  assign receiveConditionA   = s_r.condA;
  assign receiveConditionB   = s_r.condB;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSyncN || !runEnable);

  sequence jkTaken;
    jkOk;
  endsequence
  sequence codeOnPairEnd;
    s_r.codeVld && s_r.codePairEnd && s_r.phase == 3'h0;
  endsequence

  jk_realign_a : assert property (jkTaken |=> codeOnPairEnd)
    else $error("accepted JK did not realign symbol boundary");
  nrzi_decode_a : assert property (bitEvt && !rxLineDecodeBypass |=>
                                   s_r.shiftWin[0] == ($past(rawBit) ^ $past(s_r.lineLast)))
    else $error("NRZI conversion wrong");
  jk_holdoff_a : assert property (active && bitEvt && isJk && s_r.sinceJk < 5'(`FRX_JK_HOLD_BITS)
                                  |=> s_r.sinceJk != 5'h0)
    else $error("JK accepted inside hold-off");
  jk_lock_a : assert property (active && s_r.jkLock && bitEvt && isJk && !onBnd
                               |=> !s_r.codeVld)
    else $error("off-boundary JK realigned while locked");
  halt_viol_a : assert property (active && s_r.jkLock && bitEvt && isHalt && !onBnd
                                 |=> s_r.condB[1] && !s_r.codeVld)
    else $error("off-boundary halt not flagged");
  halt_lock_a : assert property (s_r.haltLock && bitEvt && isHalt && !onBnd
                                 |=> s_r.sinceHalt != 5'h0)
    else $error("halt realigned while locked");
  active_entry_a : assert property (s_r.codeVld && dec.cls == frx_pkg::FRX_SC_K && s_r.prevJ
                                    && !noSignal |=> s_r.lineCond == frx_pkg::FRX_LC_ACTIVE)
    else $error("JK pair did not enter active");
  nosig_state_a : assert property (!s_r.sdSync[1] |=>
                                   s_r.lineCond == frx_pkg::FRX_LC_UNKNOWN && s_r.condA[3])
    else $error("no signal did not force unknown");
  data_decode_a : assert property (s_r.codeVld && s_r.code == 5'h1E && !s_r.codePairEnd
                                   |=> s_r.hiSym == 4'h0 && !s_r.hiCtl)
    else $error("data code zero decoded wrong");
endmodule : frx_symbol_framing

// ### verification/frx_recovery_model.sv
/*
  Stand-in for the clock recovery stage: NRZI-encodes each requested bit
  and toggles the strobe once per bit. Assumes requests two cycles apart.
*/
`timescale 1ns/1ps
module frx_recovery_model (
  // clock
  input  wire logic clk,
  // bit requests
  input  wire logic bitIn,
  input  wire logic bitReq,
  input  wire logic sigOn,
  // pins toward the receiver
  output logic      rxBitPin,
  output logic      rxTogglePin,
  output logic      sigDetectPin
);
  initial
  begin
    rxBitPin     = 1'b0;
    rxTogglePin  = 1'b0;
    sigDetectPin = 1'b0;
  end

  always @(posedge clk)
  begin
    sigDetectPin <= sigOn;
    if (bitReq)
    begin
      // line level inverts on every one
      rxBitPin    <= rxBitPin ^ bitIn;
      rxTogglePin <= ~rxTogglePin;
    end
  end
endmodule : frx_recovery_model

// ### verification/testbench.sv
/*
  Self-checking bench of the receive framing block.
  Assumes the recovery model drives the pins; loopback bits come from here.
*/
`timescale 1ns/1ps
`include "frx_map.svh"
module testbench;
  localparam logic [4:0] DCODE [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
    5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic       clk;
  logic       reset_n;
  logic       bitIn;
  logic       bitReq;
  logic       rxBitPin;
  logic       rxTogglePin;
  logic       sigDetectPin;
  logic       loopBit;
  logic       loopBitValid;
  logic       runEnable;
  logic       shortInternalLoopback;
  logic       rxLineDecodeBypass;
  logic       framingHold;
  logic       condClearA;
  logic       condClearB;
  logic [9:0] rxByte;
  logic       rxByteValid;
  logic       rxByteReady;
  logic [1:0] currentReceiveState;
  logic [3:0] receiveConditionA;
  logic [2:0] receiveConditionB;
  logic [9:0] lastByte;
  logic       usePin;
  logic       sigOn;
  int         failures;
  int         check_count;

  frx_recovery_model partner (.clk(clk), .bitIn(bitIn), .bitReq(bitReq), .sigOn(sigOn),
    .rxBitPin(rxBitPin), .rxTogglePin(rxTogglePin), .sigDetectPin(sigDetectPin));

  frx_symbol_framing dut (.clk(clk), .reset_n(reset_n), .rxBitPin(rxBitPin),
    .rxTogglePin(rxTogglePin), .sigDetectPin(sigDetectPin), .loopBit(loopBit),
    .loopBitValid(loopBitValid), .runEnable(runEnable),
    .shortInternalLoopback(shortInternalLoopback), .rxLineDecodeBypass(rxLineDecodeBypass),
    .framingHold(framingHold), .condClearA(condClearA), .condClearB(condClearB),
    .rxByte(rxByte), .rxByteValid(rxByteValid), .rxByteReady(rxByteReady),
    .currentReceiveState(currentReceiveState), .receiveConditionA(receiveConditionA),
    .receiveConditionB(receiveConditionB));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (rxByteValid === 1'b1 && rxByteReady === 1'b1)
      lastByte <= rxByte;
  end

  task automatic print_verdict;
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic check_word(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_state(input logic [1:0] exp);
    check_count++;
    if (currentReceiveState !== exp)
    begin
      failures++;
      $display("unexpected state at %0t: got %h expected %h", $time,
        currentReceiveState, exp);
    end
  endtask : check_state

  task automatic check_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_flag

  // one bit every second cycle, first bit of the code first
  task automatic send_sym(input logic [4:0] s);
    for (int i = 4; i >= 0; i--)
    begin
      bitIn        <= s[i];
      loopBit      <= s[i];
      bitReq       <= usePin;
      loopBitValid <= ~usePin;
      @(posedge clk);
      bitReq       <= 1'b0;
      loopBitValid <= 1'b0;
      @(posedge clk);
    end
  endtask : send_sym

  task automatic send_idles;
    repeat (8) send_sym(`FRX_CODE_IDLE);
    repeat (8) @(posedge clk);
  endtask : send_idles

  task automatic send_jk;
    send_sym(`FRX_CODE_J);
    send_sym(`FRX_CODE_K);
    repeat (8) @(posedge clk);
  endtask : send_jk

  task automatic test_reset;
    check_flag(rxByteValid, 1'b0);
    check_state(frx_pkg::FRX_LC_UNKNOWN);
  endtask : test_reset

  task automatic test_idle_jk;
    send_idles();
    check_state(frx_pkg::FRX_LC_IDLE);
    check_flag(receiveConditionA[1], 1'b1);
    send_jk();
    check_state(frx_pkg::FRX_LC_ACTIVE);
    check_flag(receiveConditionA[0], 1'b1);
    check_word(lastByte, 10'h2DD);
  endtask : test_idle_jk

  task automatic test_data;
    for (int k = 0; k < 8; k++)
    begin
      send_sym(DCODE[2 * k]);
      send_sym(DCODE[2 * k + 1]);
      repeat (8) @(posedge clk);
      check_word(lastByte, {2'h0, 4'(2 * k), 4'(2 * k + 1)});
      check_state(frx_pkg::FRX_LC_ACTIVE);
    end
  endtask : test_data

  task automatic test_controls;
    send_sym(`FRX_CODE_T);
    send_sym(`FRX_CODE_T);
    repeat (8) @(posedge clk);
    check_word(lastByte, 10'h255);
    send_sym(`FRX_CODE_R);
    send_sym(`FRX_CODE_S);
    repeat (8) @(posedge clk);
    check_word(lastByte, 10'h267);
    check_state(frx_pkg::FRX_LC_ACTIVE);
    send_sym(5'h01);
    send_sym(DCODE[0]);
    repeat (8) @(posedge clk);
    check_word({1'b0, lastByte[8:0]}, 10'h120);
    check_flag(receiveConditionB[0], 1'b1);
    check_state(frx_pkg::FRX_LC_UNKNOWN);
  endtask : test_controls

  task automatic test_stall;
    rxByteReady <= 1'b0;
    repeat (6) send_sym(`FRX_CODE_IDLE);
    repeat (8) @(posedge clk);
    check_flag(rxByteValid, 1'b1);
    check_flag(receiveConditionB[2], 1'b1);
    rxByteReady <= 1'b1;
    repeat (4) @(posedge clk);
    check_flag(rxByteValid, 1'b0);
    condClearB <= 1'b1;
    @(posedge clk);
    condClearB <= 1'b0;
    repeat (2) @(posedge clk);
    check_word({7'h0, receiveConditionB}, 10'h000);
  endtask : test_stall

  task automatic test_run_low;
    runEnable <= 1'b0;
    repeat (4) @(posedge clk);
    check_state(frx_pkg::FRX_LC_UNKNOWN);
    check_flag(receiveConditionA[3], 1'b1);
    runEnable <= 1'b1;
    condClearA <= 1'b1;
    @(posedge clk);
    condClearA <= 1'b0;
    repeat (4) @(posedge clk);
    check_flag(receiveConditionA[3], 1'b0);
    sigOn <= 1'b0;
    repeat (6) @(posedge clk);
    check_state(frx_pkg::FRX_LC_UNKNOWN);
    check_flag(receiveConditionA[3], 1'b1);
    sigOn <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : test_run_low

  // halt pairs off the boundary: the first realigns, the second is locked out
  task automatic test_halt;
    send_sym(5'h1C);
    send_sym(5'h10);
    send_sym(5'h13);
    repeat (8) @(posedge clk);
    check_word({5'h00, lastByte[9], lastByte[3:0]}, 10'h011);
    send_sym(5'h1E);
    send_sym(5'h08);
    send_sym(5'h09);
    repeat (8) @(posedge clk);
    check_word(lastByte, 10'h3A8);
  endtask : test_halt

  // JK off the symbol boundary
  task automatic test_hold;
    for (int h = 1; h >= 0; h--)
    begin
      send_idles();
      framingHold <= h[0];
      send_sym(5'h1E);
      send_sym(5'h04);
      send_sym(5'h0F);
      repeat (8) @(posedge clk);
      check_state(h[0] ? frx_pkg::FRX_LC_UNKNOWN : frx_pkg::FRX_LC_ACTIVE);
      framingHold <= 1'b0;
    end
  endtask : test_hold

  task automatic test_pin_nrzi;
    usePin                <= 1'b1;
    shortInternalLoopback <= 1'b0;
    rxLineDecodeBypass    <= 1'b0;
    runEnable             <= 1'b0;
    @(posedge clk);
    runEnable             <= 1'b1;
    send_idles();
    check_state(frx_pkg::FRX_LC_IDLE);
    send_jk();
    check_state(frx_pkg::FRX_LC_ACTIVE);
    check_word(lastByte, 10'h2DD);
  endtask : test_pin_nrzi

  initial
  begin
    failures              = 0;
    check_count           = 0;
    reset_n               = 1'b0;
    bitIn                 = 1'b0;
    bitReq                = 1'b0;
    loopBit               = 1'b0;
    loopBitValid          = 1'b0;
    runEnable             = 1'b1;
    shortInternalLoopback = 1'b1;
    rxLineDecodeBypass    = 1'b1;
    framingHold           = 1'b0;
    condClearA            = 1'b0;
    condClearB            = 1'b0;
    rxByteReady           = 1'b1;
    usePin                = 1'b0;
    sigOn                 = 1'b1;
    lastByte              = 10'h000;
    repeat (3) @(posedge clk);
    test_reset();
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    test_idle_jk();
    test_data();
    test_controls();
    test_stall();
    test_run_low();
    test_halt();
    test_hold();
    test_pin_nrzi();
    print_verdict();
  end

  initial
  begin
    #(40 * 20000);
    failures++;
    print_verdict();
  end
endmodule : testbench
